// ==== rtl/cof_pkg.sv ====
package cof_pkg;
  // ===========================================================================
  // Field widths and codes
  localparam int TIME_W = 4;
  localparam int OFS_W = 4;
  localparam logic [3:0] OFFSET_ZERO = 4'h3;
  localparam logic [3:0] FAST_DECAY_NONE = 4'h0;
  // ===========================================================================
  // Timing
  localparam int CLK_HZ = 25000000;
  // One slow decay unit is 32 clocks, plus a fixed 12 clock base.
  localparam int UNIT_CLKS = 32;
  localparam logic [9:0] BASE_CLKS = 10'h00C;
  localparam logic [4:0] UNIT_LAST = 5'h1F;
  // Short detector confirms after this many retries.
  localparam logic [1:0] SHORT_RETRIES = 2'h3;
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  localparam int CNT_W = 10;
endpackage

// ==== rtl/cof_coil.sv ====
`timescale 1ns/100ps
module cof_coil
  import cof_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [TIME_W-1:0] slow_decay_time,
  input wire logic [TIME_W-1:0] fast_decay_time,
  input wire logic fd_cmp_disable,
  input wire logic [1:0] rnd_add,
  input wire logic cmp_peak,
  input wire logic cmp_neg,
  output logic [1:0] phase,
  output logic open_load
);
  // ===========================================================================
  // Chopper state
  typedef enum logic [1:0] {CC_ON, CC_FAST, CC_SLOW} cof_ph_e;
  cof_ph_e st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] on_len, next_on_len;
  logic next_open_load;
  logic [CNT_W-1:0] fast_len, slow_len;

  // Counters run down to zero inclusive, so each load is one less than the phase length.
  assign fast_len = CNT_W'({fast_decay_time, 5'h00}) + BASE_CLKS - CNT_W'(1);
  assign slow_len = CNT_W'({slow_decay_time, 5'h00}) + BASE_CLKS + CNT_W'(rnd_add) - CNT_W'(1);

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_on_len = on_len;
    next_open_load = open_load;
    if (!run) begin
      next_st = CC_SLOW;
      next_cnt = slow_len;
    end else begin
      case (st)
        CC_ON: begin
          next_on_len = on_len + CNT_W'(1);
          if (cmp_peak) begin
            next_open_load = 1'b0;
            next_on_len = '0;
            if (fast_decay_time == FAST_DECAY_NONE) begin
              next_st = CC_SLOW;
              next_cnt = slow_len;
            end else begin
              next_st = CC_FAST;
              next_cnt = fast_len;
            end
          end else if (on_len == {CNT_W{1'b1}}) begin
            // Target never reached within a full count: flag only, keep driving.
            next_open_load = 1'b1;
          end
        end
        CC_FAST: begin
          next_cnt = cnt - CNT_W'(1);
          if (cnt == '0 || (!fd_cmp_disable && cmp_neg)) begin
            next_st = CC_SLOW;
            next_cnt = slow_len;
          end
        end
        CC_SLOW: begin
          next_cnt = cnt - CNT_W'(1);
          if (cnt == '0)
            next_st = CC_ON;
        end
        default: next_st = CC_SLOW;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= CC_SLOW;
      cnt <= '0;
      on_len <= '0;
      open_load <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      on_len <= next_on_len;
      open_load <= next_open_load;
    end
  end

  assign phase = 2'(st);

  a_fast_ends_slow: assert property (@(posedge mclk) disable iff (!rst_n)
    (run && st == CC_FAST && !fd_cmp_disable && cmp_neg) |=> st == CC_SLOW)
    else $error("fast decay not ended by comparator");
  a_on_needs_cmp: assert property (@(posedge mclk) disable iff (!rst_n)
    (run && st == CC_ON && !cmp_peak) |=> st == CC_ON)
    else $error("on phase ended without comparator");
endmodule // cof_coil

// ==== rtl/cof_chopper.sv ====
`timescale 1ns/100ps
module cof_chopper
  import cof_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic driver_enable,
  input wire logic chopper_mode_select,
  input wire logic fullstep_speed_mode,
  input wire logic [3:0] slow_decay_time,
  input wire logic fast_decay_high_bit,
  input wire logic [2:0] hyst_start_field,
  input wire logic [OFS_W-1:0] sine_offset,
  input wire logic fd_cmp_disable,
  input wire logic random_off_enable,
  input wire logic signed [8:0] target_a,
  input wire logic signed [8:0] target_b,
  input wire logic cmp_peak_a_pin,
  input wire logic cmp_peak_b_pin,
  input wire logic cmp_neg_a_pin,
  input wire logic cmp_neg_b_pin,
  input wire logic temp_warn_pin,
  input wire logic temp_shut_pin,
  input wire logic short_a_pin,
  input wire logic short_b_pin,
  output logic const_off_active,
  output logic [1:0] phase_a,
  output logic [1:0] phase_b,
  output logic signed [8:0] corr_target_a,
  output logic signed [8:0] corr_target_b,
  output logic bridge_on_a,
  output logic bridge_on_b,
  output logic overtemp_warn_flag,
  output logic overtemp_shutdown_flag,
  output logic short_coil_a_flag,
  output logic short_coil_b_flag,
  output logic open_load_a_flag,
  output logic open_load_b_flag,
  output logic [5:0] driver_status_word
);
  // ===========================================================================
  // Pin synchronisers, one generate loop over all eight pin inputs
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw, s1, s2;
  assign raw = {cmp_peak_a_pin, cmp_peak_b_pin, cmp_neg_a_pin, cmp_neg_b_pin,
                temp_warn_pin, temp_shut_pin, short_a_pin, short_b_pin};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
        end else begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
        end
      end
    end
  endgenerate
  logic pk_a, pk_b, ng_a, ng_b, t_warn, t_shut, sh_a, sh_b;
  assign {pk_a, pk_b, ng_a, ng_b, t_warn, t_shut, sh_a, sh_b} = s2;

  // ===========================================================================
  // Mode, decay field and random generator
  logic use_cof;
  logic [TIME_W-1:0] fd_time;
  assign use_cof = chopper_mode_select | fullstep_speed_mode;
  assign fd_time = {fast_decay_high_bit, hyst_start_field};

  logic [7:0] lfsr, next_lfsr;
  logic [1:0] rnd_a, rnd_b;
  always_comb begin
    next_lfsr = {lfsr[6:0], ^(lfsr & LFSR_TAPS)};
  end
  assign rnd_a = random_off_enable ? lfsr[1:0] : 2'h0;
  assign rnd_b = random_off_enable ? lfsr[5:4] : 2'h0;

  // ===========================================================================
  // Protection state
  logic ot, next_ot, owarn, next_owarn;
  logic [1:0] try_a, try_b, next_try_a, next_try_b;
  logic sfa, sfb, next_sfa, next_sfb;
  logic run_a, run_b;

  always_comb begin
    next_owarn = t_warn;
    next_ot = ot;
    if (t_shut)
      next_ot = 1'b1;
    else if (!t_warn)
      next_ot = 1'b0;
    next_try_a = try_a;
    next_try_b = try_b;
    next_sfa = sfa;
    next_sfb = sfb;
    if (!driver_enable) begin
      // Clearing by disable is the only restart path; no short detection runs while disabled.
      next_sfa = 1'b0;
      next_sfb = 1'b0;
      next_try_a = 2'h0;
      next_try_b = 2'h0;
    end else begin
      if (sh_a) begin
        if (try_a == SHORT_RETRIES)
          next_sfa = 1'b1;
        else
          next_try_a = try_a + 2'h1;
      end
      if (sh_b) begin
        if (try_b == SHORT_RETRIES)
          next_sfb = 1'b1;
        else
          next_try_b = try_b + 2'h1;
      end
    end
  end

  assign run_a = driver_enable & use_cof & ~ot & ~sfa;
  assign run_b = driver_enable & use_cof & ~ot & ~sfb;

  // ===========================================================================
  // Two independent coil choppers
  logic [1:0] ph_a, ph_b;
  logic ol_a, ol_b;
  cof_coil u_coil_a (.mclk(mclk), .rst_n(rst_n), .run(run_a),
    .slow_decay_time(slow_decay_time), .fast_decay_time(fd_time),
    .fd_cmp_disable(fd_cmp_disable), .rnd_add(rnd_a), .cmp_peak(pk_a),
    .cmp_neg(ng_a), .phase(ph_a), .open_load(ol_a));
  cof_coil u_coil_b (.mclk(mclk), .rst_n(rst_n), .run(run_b),
    .slow_decay_time(slow_decay_time), .fast_decay_time(fd_time),
    .fd_cmp_disable(fd_cmp_disable), .rnd_add(rnd_b), .cmp_peak(pk_b),
    .cmp_neg(ng_b), .phase(ph_b), .open_load(ol_b));

  // ===========================================================================
  // Offset correction pushes target away from zero in its own sign.
  function automatic logic signed [8:0] add_ofs(input logic signed [8:0] t,
                                                input logic [OFS_W-1:0] o);
    logic signed [8:0] d;
    d = 9'(signed'({1'b0, o})) - 9'(signed'({1'b0, OFFSET_ZERO}));
    add_ofs = t[8] ? t - d : t + d;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= LFSR_SEED;
      ot <= 1'b0;
      owarn <= 1'b0;
      try_a <= 2'h0;
      try_b <= 2'h0;
      sfa <= 1'b0;
      sfb <= 1'b0;
      const_off_active <= 1'b0;
      phase_a <= 2'h0;
      phase_b <= 2'h0;
      corr_target_a <= '0;
      corr_target_b <= '0;
      bridge_on_a <= 1'b0;
      bridge_on_b <= 1'b0;
      overtemp_warn_flag <= 1'b0;
      overtemp_shutdown_flag <= 1'b0;
      short_coil_a_flag <= 1'b0;
      short_coil_b_flag <= 1'b0;
      open_load_a_flag <= 1'b0;
      open_load_b_flag <= 1'b0;
      driver_status_word <= 6'h00;
    end else begin
      lfsr <= next_lfsr;
      ot <= next_ot;
      owarn <= next_owarn;
      try_a <= next_try_a;
      try_b <= next_try_b;
      sfa <= next_sfa;
      sfb <= next_sfb;
      const_off_active <= use_cof;
      phase_a <= ph_a;
      phase_b <= ph_b;
      corr_target_a <= add_ofs(target_a, sine_offset);
      corr_target_b <= add_ofs(target_b, sine_offset);
      bridge_on_a <= run_a;
      bridge_on_b <= run_b;
      overtemp_warn_flag <= owarn;
      overtemp_shutdown_flag <= ot;
      short_coil_a_flag <= sfa;
      short_coil_b_flag <= sfb;
      open_load_a_flag <= ol_a;
      open_load_b_flag <= ol_b;
      driver_status_word <= {owarn, ot, sfb, sfa, ol_b, ol_a};
    end
  end

  a_ot_holds_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (ot && t_warn) |=> ot)
    else $error("shutdown released above warning level");
  a_short_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (sfa && driver_enable) |=> sfa)
    else $error("short flag dropped while enabled");
  a_short_retry: assert property (@(posedge mclk) disable iff (!rst_n)
    (driver_enable && !sfa && try_a != SHORT_RETRIES) |=> !sfa)
    else $error("short latched before retries");
  a_bridge_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (sfa || ot) |-> !run_a)
    else $error("bridge A on during fault");
  a_mode_forced: assert property (@(posedge mclk) disable iff (!rst_n)
    fullstep_speed_mode |=> const_off_active)
    else $error("fullstep mode not forcing const off");
  a_status_map: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> driver_status_word[2] == $past(sfa))
    else $error("status short bit wrong");
endmodule // cof_chopper

// ==== bench/cof_bridge_model.sv ====
`timescale 1ns/100ps
// ============================================================
// Coil bridge and comparator model
// Current rises only while the bridge drives the on phase, so a dead coil never peaks.
module cof_bridge_model #(
  parameter int RISE = 20,
  parameter int FALL = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] phase,
  input wire logic bridge_on,
  input wire logic open_coil,
  input wire logic neg_early,
  output logic cmp_peak,
  output logic cmp_neg
);
  int rise_cnt;
  int fall_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 0;
      fall_cnt <= 0;
    end else begin
      rise_cnt <= (phase == 2'h0 && bridge_on && !open_coil) ? rise_cnt + 1 : 0;
      fall_cnt <= (phase == 2'h1) ? fall_cnt + 1 : 0;
    end
  end
  assign cmp_peak = (rise_cnt >= RISE);
  assign cmp_neg = neg_early && (fall_cnt >= FALL);
endmodule // cof_bridge_model

// ==== bench/tb.sv ====
`timescale 1ns/100ps
module tb;
  import cof_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic drv_en, mode, fs, hi, fdd, rnd, open_a, neg_e, tw, ts, sa, sb;
  logic [3:0] sdt;
  logic [2:0] hs;
  logic [OFS_W-1:0] ofs;
  logic signed [8:0] ta, tb_t;
  logic pa, pb, na, nb, coa, bra, brb, owf, otf, sfa, sfb, ola, olb;
  logic [1:0] ph_a, ph_b;
  logic signed [8:0] ca, cb;
  logic [5:0] dsw;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] seed;
  int len, lo, hi_l, i, k, nb_on;
  logic signed [8:0] t;
  always #20 mclk = ~mclk;
  cof_chopper dut_u (.mclk(mclk), .rst_n(rst_n), .driver_enable(drv_en),
    .chopper_mode_select(mode), .fullstep_speed_mode(fs), .slow_decay_time(sdt),
    .fast_decay_high_bit(hi), .hyst_start_field(hs), .sine_offset(ofs), .fd_cmp_disable(fdd),
    .random_off_enable(rnd), .target_a(ta), .target_b(tb_t), .cmp_peak_a_pin(pa),
    .cmp_peak_b_pin(pb), .cmp_neg_a_pin(na), .cmp_neg_b_pin(nb), .temp_warn_pin(tw),
    .temp_shut_pin(ts), .short_a_pin(sa), .short_b_pin(sb), .const_off_active(coa),
    .phase_a(ph_a), .phase_b(ph_b), .corr_target_a(ca), .corr_target_b(cb),
    .bridge_on_a(bra), .bridge_on_b(brb), .overtemp_warn_flag(owf),
    .overtemp_shutdown_flag(otf), .short_coil_a_flag(sfa), .short_coil_b_flag(sfb),
    .open_load_a_flag(ola), .open_load_b_flag(olb), .driver_status_word(dsw));
  cof_bridge_model mdl_a (.mclk(mclk), .rst_n(rst_n), .phase(ph_a), .bridge_on(bra),
    .open_coil(open_a), .neg_early(neg_e), .cmp_peak(pa), .cmp_neg(na));
  cof_bridge_model mdl_b (.mclk(mclk), .rst_n(rst_n), .phase(ph_b), .bridge_on(brb),
    .open_coil(1'b0), .neg_early(neg_e), .cmp_peak(pb), .cmp_neg(nb));
  // ============================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // The offset pushes away from zero, so a nonzero target is used throughout.
  function automatic logic signed [8:0] exp_corr(input logic signed [8:0] v, input logic [3:0] c);
    int d;
    d = int'(c) - 3;
    return (v < 0) ? 9'(int'(v) - d) : 9'(int'(v) + d);
  endfunction
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %b seen %b", n, e, g);
      fail_count++;
    end
  endtask
  task automatic chk_val(input string n, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic chk_len(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic hang(input string n);
    chk_bit(n, 1'b1, 1'b0);
    wrap_up();
  endtask
  // Measures one whole run of phase p on coil A, starting from its next entry.
  task automatic meas(input logic [1:0] p, output int n);
    int j;
    n = 0;
    for (j = 0; j < 3000 && ph_a === p; j++) @(negedge mclk);
    for (j = 0; j < 3000 && ph_a !== p; j++) @(negedge mclk);
    for (n = 0; n < 3000 && ph_a === p; n++) @(negedge mclk);
    if (n >= 3000 || j >= 3000) hang("phase_wait");
  endtask
  // ============================================================
  // Main sequence
  initial begin
    {drv_en, mode, fs, hi, fdd, rnd, open_a, neg_e, tw, ts, sa, sb} = 12'h800;
    sdt = 4'h1;
    hs = 3'h1;
    ofs = OFFSET_ZERO;
    ta = 9'h040;
    tb_t = 9'h040;
    seed = 32'h75B96055;
    cyc(2);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk_val("status_reset", 9'(6'h00), 9'(dsw));
    cyc(6);
    @(negedge mclk);
    chk_bit("const_off_hyst", 1'b0, coa);
    chk_bit("bridge_hyst", 1'b0, bra);
    @(posedge mclk);
    fs <= 1'b1;
    cyc(6);
    @(negedge mclk);
    chk_bit("const_off_fullstep", 1'b1, coa);
    @(posedge mclk);
    fs <= 1'b0;
    mode <= 1'b1;
    fdd <= 1'b1;
    cyc(6);
    @(negedge mclk);
    chk_bit("const_off_sel", 1'b1, coa);
    for (k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      t = 9'(int'(seed[6:0]) + 1);
      t = seed[8] ? -t : t;
      @(posedge mclk);
      ta <= t;
      tb_t <= -t;
      ofs <= 4'(k);
      cyc(5);
      @(negedge mclk);
      chk_val("corr_a", exp_corr(t, 4'(k)), ca);
      chk_val("corr_b", exp_corr(-t, 4'(k)), cb);
    end
    meas(2'h1, len);
    chk_len("fast_len_1", 12 + 32 * 1, len);
    meas(2'h2, len);
    chk_len("slow_len_1", 12 + 32 * 1, len);
    @(posedge mclk);
    hi <= 1'b1;
    hs <= 3'h0;
    meas(2'h1, len);
    meas(2'h1, len);
    chk_len("fast_len_8", 12 + 32 * 8, len);
    @(posedge mclk);
    fdd <= 1'b0;
    neg_e <= 1'b1;
    meas(2'h1, len);
    meas(2'h1, len);
    chk_bit("fast_cmp_end", 1'b1, len < 12 + 32 * 8);
    @(posedge mclk);
    hi <= 1'b0;
    hs <= 3'h1;
    rnd <= 1'b1;
    lo = 9999;
    hi_l = 0;
    for (k = 0; k < 10; k++) begin
      meas(2'h2, len);
      lo = (len < lo) ? len : lo;
      hi_l = (len > hi_l) ? len : hi_l;
    end
    chk_bit("rnd_range", 1'b1, lo >= 44 && hi_l <= 47);
    chk_bit("rnd_varies", 1'b1, hi_l > lo);
    @(posedge mclk);
    rnd <= 1'b0;
    {hi, hs} <= 4'h0;
    cyc(400);
    len = 0;
    for (k = 0; k < 400; k++) begin
      @(negedge mclk);
      len += (ph_a === 2'h1) ? 1 : 0;
    end
    chk_len("no_fast_phase", 0, len);
    @(posedge mclk);
    hs <= 3'h1;
    open_a <= 1'b1;
    nb_on = 0;
    for (i = 0; i < 1400 && ola !== 1'b1; i++) begin
      @(negedge mclk);
      nb_on += (ph_b === 2'h0) ? 1 : 0;
    end
    if (i >= 1400) hang("open_load_wait");
    chk_bit("on_held_a", 1'b1, ph_a === 2'h0);
    chk_bit("bridge_kept_a", 1'b1, bra);
    chk_bit("status_ol_a", 1'b1, dsw[0]);
    chk_bit("coil_b_runs", 1'b1, nb_on > 0 && nb_on < i);
    chk_bit("ol_b_clear", 1'b0, olb);
    chk_bit("status_ol_b", 1'b0, dsw[1]);
    @(posedge mclk);
    open_a <= 1'b0;
    for (i = 0; i < 200 && ola !== 1'b0; i++) @(negedge mclk);
    chk_bit("ol_a_clears", 1'b0, ola);
    @(posedge mclk);
    tw <= 1'b1;
    cyc(8);
    @(negedge mclk);
    chk_bit("warn_flag", 1'b1, dsw[5] & owf);
    @(posedge mclk);
    ts <= 1'b1;
    cyc(8);
    @(negedge mclk);
    chk_bit("ot_flag", 1'b1, dsw[4] & otf);
    chk_bit("ot_bridges", 1'b0, bra | brb);
    @(posedge mclk);
    ts <= 1'b0;
    cyc(8);
    @(negedge mclk);
    chk_bit("ot_hold", 1'b1, otf & ~bra);
    @(posedge mclk);
    tw <= 1'b0;
    cyc(8);
    @(negedge mclk);
    chk_bit("ot_release", 1'b1, ~otf & bra);
    @(posedge mclk);
    sa <= 1'b1;
    cyc(3);
    sa <= 1'b0;
    cyc(8);
    @(negedge mclk);
    chk_bit("short_retry", 1'b1, ~sfa & bra);
    @(posedge mclk);
    sa <= 1'b1;
    cyc(1);
    sa <= 1'b0;
    cyc(8);
    @(negedge mclk);
    chk_bit("short_latch", 1'b1, sfa & dsw[2] & ~bra & brb & ~sfb);
    chk_bit("status_short_b", 1'b0, dsw[3]);
    @(posedge mclk);
    drv_en <= 1'b0;
    cyc(4);
    drv_en <= 1'b1;
    cyc(8);
    @(negedge mclk);
    chk_bit("short_restart", 1'b1, ~sfa & bra);
    wrap_up();
  end
endmodule // tb
